// >>> src/dtoc_pkg.sv
// Constants, types and helpers for the DAC tuning and offset calibration register bank
package dtoc_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int unsigned DTOC_NUM_REGS     = 11;
    localparam int unsigned DTOC_IDX_W        = 4;
    localparam logic [7:0]  DTOC_ADDR_FIRST   = 8'h07;
    localparam logic [7:0]  DTOC_ADDR_LAST    = 8'h11;

    localparam logic [7:0]  DTOC_SPARE_TUNING_A          = 8'h07;
    localparam logic [7:0]  DTOC_SPARE_TUNING_B          = 8'h08;
    localparam logic [7:0]  DTOC_SPARE_TUNING_C          = 8'h09;
    localparam logic [7:0]  DTOC_DITHER_OPTION_RESERVED  = 8'h0a;
    localparam logic [7:0]  DTOC_OFFSET_CAL_CONFIG       = 8'h0b;
    localparam logic [7:0]  DTOC_DITHER_OPTION_105DB     = 8'h0c;
    localparam logic [7:0]  DTOC_DITHER_OPTION_110DB     = 8'h0d;
    localparam logic [7:0]  DTOC_SPEEDUP_CONTROL         = 8'h0e;
    localparam logic [7:0]  DTOC_SHORT_AND_OFFSET_CTRL   = 8'h0f;
    localparam logic [7:0]  DTOC_SHUFFLE_AND_DITHER_POL  = 8'h10;
    localparam logic [7:0]  DTOC_DAC_SECONDARY_SCALE     = 8'h11;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0]  DTOC_RST_ZERO                = 8'h00;
    localparam logic [7:0]  DTOC_RST_SHORT_AND_OFFSET    = 8'h10;
    localparam logic [7:0]  DTOC_RST_SHUFFLE             = 8'h20;
    localparam logic [7:0]  DTOC_RDATA_NONE              = 8'h00;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int unsigned DTOC_B_DITHER_BOND           = 7;
    localparam int unsigned DTOC_B_CAL_FILTER_BYPASS     = 4;
    localparam int unsigned DTOC_B_CAL_FILTER_FULL_SPAN  = 3;
    localparam int unsigned DTOC_B_CAL_FILTER_AVERAGING  = 2;
    localparam int unsigned DTOC_B_CAL_SKIP_FINE_STEPS   = 1;
    localparam int unsigned DTOC_B_CAL_SKIP_POST_AVERAGE = 0;
    localparam int unsigned DTOC_B_FAST_CLOCK_LOSS       = 4;
    localparam int unsigned DTOC_B_FAST_ANALOG_SEQ       = 0;
    localparam int unsigned DTOC_B_SHORT_DETECT_OFF      = 4;
    localparam int unsigned DTOC_B_LATER_OFS_CANCEL_OFF  = 0;
    localparam int unsigned DTOC_B_SHUFFLE_HI            = 5;
    localparam int unsigned DTOC_B_SHUFFLE_LO            = 4;
    localparam int unsigned DTOC_B_SEC_DITHER_POLARITY   = 0;
    localparam int unsigned DTOC_B_LEFT_SEC_SCALE        = 7;
    localparam int unsigned DTOC_B_RIGHT_SEC_SCALE       = 3;

    // ----------------------------------------------------------------
    // Calibration step counts
    // ----------------------------------------------------------------
    localparam logic [6:0]  DTOC_COARSE_STEPS_NORMAL     = 7'h40;
    localparam logic [6:0]  DTOC_FINE_STEPS              = 7'h20;
    localparam logic [6:0]  DTOC_COARSE_STEPS_ONLY       = 7'h60;
    localparam logic [6:0]  DTOC_STEP_ONE                = 7'h01;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        DTOC_SHUF_NONE     = 2'h0,
        DTOC_SHUF_INTERNAL = 2'h1,
        DTOC_SHUF_GLOBAL   = 2'h2,
        DTOC_SHUF_NONE_ALT = 2'h3
    } dtoc_shuffle_t;

    typedef enum logic [1:0] {
        DTOC_BOND_RESERVED   = 2'h0,
        DTOC_BOND_RESERVED_B = 2'h1,
        DTOC_BOND_105DB      = 2'h2,
        DTOC_BOND_110DB      = 2'h3
    } dtoc_bond_t;

    typedef enum logic [3:0] {
        DTOC_ST_IDLE   = 4'h1,
        DTOC_ST_COARSE = 4'h2,
        DTOC_ST_FINE   = 4'h4,
        DTOC_ST_DONE   = 4'h8
    } dtoc_cal_state_t;

    typedef struct packed {
        logic filter_bypass;
        logic filter_full_span;
        logic filter_averaging;
        logic skip_fine_steps;
        logic skip_post_average;
    } dtoc_cal_cfg_t;

    // Reset value of the register at a given bank index
    function automatic logic [7:0] dtoc_reset_val(input int unsigned idx);
        logic [7:0] v;
        v = DTOC_RST_ZERO;
        if (idx == 32'(DTOC_SHORT_AND_OFFSET_CTRL - DTOC_ADDR_FIRST))
            v = DTOC_RST_SHORT_AND_OFFSET;
        else if (idx == 32'(DTOC_SHUFFLE_AND_DITHER_POL - DTOC_ADDR_FIRST))
            v = DTOC_RST_SHUFFLE;
        return v;
    endfunction

endpackage

// >>> src/dtoc_reg8.sv
// One 8-bit read/write register cell with a parameterised reset value
`timescale 1ns/1ps
`default_nettype none

module dtoc_reg8
    import dtoc_pkg::*;
#(
    parameter logic [7:0] RST_VAL = 8'h00
)
(
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_ce,
    // Write port
    input  wire logic       i_we,
    input  wire logic [7:0] i_wdata,
    // Stored value
    output logic      [7:0] o_q
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_q <= RST_VAL;
        else if (i_ce && i_we)
            o_q <= i_wdata;
    end

endmodule

`default_nettype wire

// >>> src/dtoc_regs.sv
// Register bank for DAC dither, offset calibration, speed-up, shuffle and scaling controls
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Bit4 of 0x0B bypasses calibration front-end filter
// - Bit3 of 0x0B: filter active whole period
// - Bit2 of 0x0B: averaging instead of majority filter
// - Bit1 of 0x0B: 96 coarse, else 64+32
// - Bit0 of 0x0B: use integrator, not post-average
// - Bit4 of 0x0F resets 1, disables short detect
// - Bit0 of 0x0F blocks offset cancels after first
// - Bit4 of 0x0E speeds missing-clock detection
// - Bit0 of 0x0E speeds analog power-up sequence
// - Bits5-4 of 0x10: none, internal, global shuffle
// - Bit0 of 0x10 picks secondary dither polarity
// - Bit7 of 0x0A-0x0D dither per bond option
// - 0x11 bits 7,3 left/right secondary scale
module dtoc_regs
    import dtoc_pkg::*;
(
    // Clock, reset, enable
    input  wire logic            I_MCLK,
    input  wire logic            I_NRST,
    input  wire logic            I_CE,
    // Register port from the control interface
    input  wire logic            I_WR_EN,
    input  wire logic            I_RD_EN,
    input  wire logic [7:0]      I_ADDR,
    input  wire logic [7:0]      I_WDATA,
    output logic      [7:0]      O_RDATA,
    output logic                 O_RVALID,
    // Bond option pins
    input  wire logic [1:0]      I_BOND_OPT,
    // Calibration handshake
    input  wire logic            I_CAL_START,
    input  wire logic            I_CAL_STEP,
    input  wire logic            I_CAL_SECOND_HALF,
    input  wire logic            I_OFS_CANCEL_REQ,
    // Calibration controls
    output dtoc_cal_cfg_t        O_CAL_CFG,
    output logic                 O_CAL_FILTER_ACTIVE,
    output logic                 O_CAL_COARSE,
    output logic                 O_CAL_FINE,
    output logic                 O_CAL_DONE,
    output logic      [6:0]      O_CAL_STEP_IDX,
    output logic                 O_OFS_CANCEL_GO,
    // Analog and DAC controls
    output logic                 O_SHORT_DETECT_EN,
    output logic                 O_FAST_CLOCK_LOSS_DETECT,
    output logic                 O_FAST_ANALOG_SEQUENCE,
    output dtoc_shuffle_t        O_ELEMENT_SHUFFLE,
    output logic                 O_SEC_DITHER_NEGATIVE,
    output logic                 O_DITHER_SETTING,
    output logic                 O_LEFT_SECONDARY_SCALE,
    output logic                 O_RIGHT_SECONDARY_SCALE
);

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    function automatic logic addr_hit(input logic [7:0] a);
        return (a >= DTOC_ADDR_FIRST) && (a <= DTOC_ADDR_LAST);
    endfunction
    function automatic logic [DTOC_IDX_W-1:0] addr_index(input logic [7:0] a);
        logic [7:0] d;
        d = a - DTOC_ADDR_FIRST;
        return d[DTOC_IDX_W-1:0];
    endfunction
    logic                  wr_hit;
    logic [DTOC_IDX_W-1:0] wr_idx;
    logic [DTOC_IDX_W-1:0] rd_idx;
    logic [7:0]            reg_q [DTOC_NUM_REGS];
    assign wr_hit = I_WR_EN && addr_hit(I_ADDR);
    assign wr_idx = addr_index(I_ADDR);
    assign rd_idx = addr_index(I_ADDR);

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    // Every bit is stored, reserved or not, so software reads back what it wrote
    genvar g;
    generate
        for (g = 0; g < DTOC_NUM_REGS; g = g + 1)
        begin : g_reg
            dtoc_reg8 #(
                .RST_VAL (dtoc_reset_val(g))
            ) u_reg (
                .i_clk   (I_MCLK),
                .i_rst_n (I_NRST),
                .i_ce    (I_CE),
                .i_we    (wr_hit && (wr_idx == DTOC_IDX_W'(g))),
                .i_wdata (I_WDATA),
                .o_q     (reg_q[g])
            );
        end
    endgenerate

    // Named views of the bank
    localparam int unsigned IX_DITH_RSV  = 32'(DTOC_DITHER_OPTION_RESERVED - DTOC_ADDR_FIRST);
    localparam int unsigned IX_CAL_CFG   = 32'(DTOC_OFFSET_CAL_CONFIG - DTOC_ADDR_FIRST);
    localparam int unsigned IX_DITH_105  = 32'(DTOC_DITHER_OPTION_105DB - DTOC_ADDR_FIRST);
    localparam int unsigned IX_DITH_110  = 32'(DTOC_DITHER_OPTION_110DB - DTOC_ADDR_FIRST);
    localparam int unsigned IX_SPEEDUP   = 32'(DTOC_SPEEDUP_CONTROL - DTOC_ADDR_FIRST);
    localparam int unsigned IX_SHORT_OFS = 32'(DTOC_SHORT_AND_OFFSET_CTRL - DTOC_ADDR_FIRST);
    localparam int unsigned IX_SHUF_POL  = 32'(DTOC_SHUFFLE_AND_DITHER_POL - DTOC_ADDR_FIRST);
    localparam int unsigned IX_SCALE     = 32'(DTOC_DAC_SECONDARY_SCALE - DTOC_ADDR_FIRST);
    logic [7:0] cal_reg;
    logic       cal_filter_bypass;
    logic       cal_filter_full_span;
    logic       cal_filter_averaging;
    logic       cal_skip_fine_steps;
    logic       cal_skip_post_average;
    logic       later_offset_cancel_off;
    assign cal_reg                 = reg_q[IX_CAL_CFG];
    assign cal_filter_bypass       = cal_reg[DTOC_B_CAL_FILTER_BYPASS];
    assign cal_filter_full_span    = cal_reg[DTOC_B_CAL_FILTER_FULL_SPAN];
    assign cal_filter_averaging    = cal_reg[DTOC_B_CAL_FILTER_AVERAGING];
    assign cal_skip_fine_steps     = cal_reg[DTOC_B_CAL_SKIP_FINE_STEPS];
    assign cal_skip_post_average   = cal_reg[DTOC_B_CAL_SKIP_POST_AVERAGE];
    assign later_offset_cancel_off = reg_q[IX_SHORT_OFS][DTOC_B_LATER_OFS_CANCEL_OFF];

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Unmapped addresses read as zero; writes to them are dropped
    always_ff @(posedge I_MCLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            O_RDATA  <= DTOC_RDATA_NONE;
            O_RVALID <= 1'b0;
        end
        else if (I_CE)
        begin
            O_RVALID <= I_RD_EN;
            if (I_RD_EN)
                O_RDATA <= addr_hit(I_ADDR) ? reg_q[rd_idx] : DTOC_RDATA_NONE;
        end
    end

    // ----------------------------------------------------------------
    // Bond option synchroniser
    // ----------------------------------------------------------------
    logic [1:0] bond_meta_q;
    logic [1:0] bond_sync_q;
    always_ff @(posedge I_MCLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            bond_meta_q <= 2'h0;
            bond_sync_q <= 2'h0;
        end
        else if (I_CE)
        begin
            bond_meta_q <= I_BOND_OPT;
            bond_sync_q <= bond_meta_q;
        end
    end

    // ----------------------------------------------------------------
    // Dither setting per bond option
    // ----------------------------------------------------------------
    logic dither_d;
    always_comb
    begin
        case (dtoc_bond_t'(bond_sync_q))
            DTOC_BOND_RESERVED:   dither_d = reg_q[IX_DITH_RSV][DTOC_B_DITHER_BOND];
            DTOC_BOND_RESERVED_B: dither_d = cal_reg[DTOC_B_DITHER_BOND];
            DTOC_BOND_105DB:      dither_d = reg_q[IX_DITH_105][DTOC_B_DITHER_BOND];
            DTOC_BOND_110DB:      dither_d = reg_q[IX_DITH_110][DTOC_B_DITHER_BOND];
            default:              dither_d = 1'b0;
        endcase
    end
    always_ff @(posedge I_MCLK or negedge I_NRST)
    begin
        if (!I_NRST)
            O_DITHER_SETTING <= 1'b0;
        else if (I_CE)
            O_DITHER_SETTING <= dither_d;
    end

    // ----------------------------------------------------------------
    // Static analog and DAC controls
    // ----------------------------------------------------------------
    always_ff @(posedge I_MCLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            O_SHORT_DETECT_EN        <= 1'b0;
            O_FAST_CLOCK_LOSS_DETECT <= 1'b0;
            O_FAST_ANALOG_SEQUENCE   <= 1'b0;
            O_SEC_DITHER_NEGATIVE    <= 1'b0;
            O_LEFT_SECONDARY_SCALE   <= 1'b0;
            O_RIGHT_SECONDARY_SCALE  <= 1'b0;
        end
        else if (I_CE)
        begin
            O_SHORT_DETECT_EN        <= !reg_q[IX_SHORT_OFS][DTOC_B_SHORT_DETECT_OFF];
            O_FAST_CLOCK_LOSS_DETECT <= reg_q[IX_SPEEDUP][DTOC_B_FAST_CLOCK_LOSS];
            O_FAST_ANALOG_SEQUENCE   <= reg_q[IX_SPEEDUP][DTOC_B_FAST_ANALOG_SEQ];
            O_SEC_DITHER_NEGATIVE    <= reg_q[IX_SHUF_POL][DTOC_B_SEC_DITHER_POLARITY];
            O_LEFT_SECONDARY_SCALE   <= reg_q[IX_SCALE][DTOC_B_LEFT_SEC_SCALE];
            O_RIGHT_SECONDARY_SCALE  <= reg_q[IX_SCALE][DTOC_B_RIGHT_SEC_SCALE];
        end
    end

    // ----------------------------------------------------------------
    // Element shuffle select
    // ----------------------------------------------------------------
    logic [1:0]    shuf_raw;
    dtoc_shuffle_t shuf_d;
    assign shuf_raw = reg_q[IX_SHUF_POL][DTOC_B_SHUFFLE_HI:DTOC_B_SHUFFLE_LO];

    // Code 3 folds onto code 0 so downstream only sees three modes
    always_comb
    begin
        case (dtoc_shuffle_t'(shuf_raw))
            DTOC_SHUF_INTERNAL: shuf_d = DTOC_SHUF_INTERNAL;
            DTOC_SHUF_GLOBAL:   shuf_d = DTOC_SHUF_GLOBAL;
            default:            shuf_d = DTOC_SHUF_NONE;
        endcase
    end
    always_ff @(posedge I_MCLK or negedge I_NRST)
    begin
        if (!I_NRST)
            O_ELEMENT_SHUFFLE <= DTOC_SHUF_NONE;
        else if (I_CE)
            O_ELEMENT_SHUFFLE <= shuf_d;
    end

    // ----------------------------------------------------------------
    // Calibration configuration
    // ----------------------------------------------------------------
    always_ff @(posedge I_MCLK or negedge I_NRST)
    begin
        if (!I_NRST)
            O_CAL_CFG <= '0;
        else if (I_CE)
        begin
            O_CAL_CFG.filter_bypass     <= cal_filter_bypass;
            O_CAL_CFG.filter_full_span  <= cal_filter_full_span;
            O_CAL_CFG.filter_averaging  <= cal_filter_averaging;
            O_CAL_CFG.skip_fine_steps   <= cal_skip_fine_steps;
            O_CAL_CFG.skip_post_average <= cal_skip_post_average;
        end
    end

    // ----------------------------------------------------------------
    // Calibration step sequencer
    // ----------------------------------------------------------------
    dtoc_cal_state_t state_q;
    dtoc_cal_state_t state_d;
    logic [6:0]      step_q;
    logic [6:0]      step_d;
    logic            skip_fine_q;
    logic [6:0]      coarse_limit;
    logic            step_last;
    // Sequence choice is latched at start so a mid-run write cannot truncate it
    assign coarse_limit = skip_fine_q ? DTOC_COARSE_STEPS_ONLY : DTOC_COARSE_STEPS_NORMAL;
    assign step_last    = (state_q == DTOC_ST_COARSE) ? (step_q == coarse_limit - DTOC_STEP_ONE)
                                                      : (step_q == DTOC_FINE_STEPS - DTOC_STEP_ONE);
    always_comb
    begin
        state_d = state_q;
        step_d  = step_q;
        case (state_q)
            DTOC_ST_IDLE:
            begin
                step_d = '0;
                if (I_CAL_START)
                    state_d = DTOC_ST_COARSE;
            end
            DTOC_ST_COARSE, DTOC_ST_FINE:
            begin
                if (I_CAL_STEP)
                begin
                    step_d = step_q + DTOC_STEP_ONE;
                    if (step_last)
                    begin
                        step_d  = '0;
                        state_d = (skip_fine_q || state_q == DTOC_ST_FINE)
                                  ? DTOC_ST_DONE : DTOC_ST_FINE;
                    end
                end
            end
            default:
            begin
                step_d  = '0;
                state_d = DTOC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_MCLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            state_q     <= DTOC_ST_IDLE;
            step_q      <= '0;
            skip_fine_q <= 1'b0;
        end
        else if (I_CE)
        begin
            state_q <= state_d;
            step_q  <= step_d;
            if (state_q == DTOC_ST_IDLE && I_CAL_START)
                skip_fine_q <= cal_skip_fine_steps;
        end
    end

    always_ff @(posedge I_MCLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            O_CAL_COARSE   <= 1'b0;
            O_CAL_FINE     <= 1'b0;
            O_CAL_DONE     <= 1'b0;
            O_CAL_STEP_IDX <= '0;
        end
        else if (I_CE)
        begin
            O_CAL_COARSE   <= (state_d == DTOC_ST_COARSE);
            O_CAL_FINE     <= (state_d == DTOC_ST_FINE);
            O_CAL_DONE     <= (state_d == DTOC_ST_DONE);
            O_CAL_STEP_IDX <= step_d;
        end
    end

    // ----------------------------------------------------------------
    // Front-end filter window
    // ----------------------------------------------------------------
    logic cal_running;
    assign cal_running = (state_q == DTOC_ST_COARSE) || (state_q == DTOC_ST_FINE);
    always_ff @(posedge I_MCLK or negedge I_NRST)
    begin
        if (!I_NRST)
            O_CAL_FILTER_ACTIVE <= 1'b0;
        else if (I_CE)
            O_CAL_FILTER_ACTIVE <= cal_running && !cal_filter_bypass
                                   && (cal_filter_full_span || I_CAL_SECOND_HALF);
    end

    // ----------------------------------------------------------------
    // Offset cancellation gate
    // ----------------------------------------------------------------
    // The first cancellation after reset always runs; only later ones are gated
    logic first_cancel_done_q;
    always_ff @(posedge I_MCLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            first_cancel_done_q <= 1'b0;
            O_OFS_CANCEL_GO     <= 1'b0;
        end
        else if (I_CE)
        begin
            O_OFS_CANCEL_GO <= I_OFS_CANCEL_REQ
                               && (!first_cancel_done_q || !later_offset_cancel_off);
            if (I_OFS_CANCEL_REQ)
                first_cancel_done_q <= 1'b1;
        end
    end

endmodule

`default_nettype wire

// >>> tb/dtoc_regs_asserts.sv
// Port-level checks for the tuning register bank
`timescale 1ns/1ps
`default_nettype none
module dtoc_regs_asserts
    import dtoc_pkg::*;
(
    // Clock, reset, enable
    input wire logic          I_MCLK,
    input wire logic          I_NRST,
    input wire logic          I_CE,
    // Register port
    input wire logic          I_WR_EN,
    input wire logic          I_RD_EN,
    input wire logic [7:0]    I_ADDR,
    input wire logic [7:0]    I_WDATA,
    input wire logic          O_RVALID,
    // Controls
    input wire logic          I_OFS_CANCEL_REQ,
    input wire logic          O_OFS_CANCEL_GO,
    input wire dtoc_cal_cfg_t O_CAL_CFG,
    input wire logic          O_CAL_COARSE,
    input wire logic          O_CAL_FINE,
    input wire logic          O_CAL_DONE,
    input wire logic          O_SHORT_DETECT_EN,
    input wire logic          O_FAST_CLOCK_LOSS_DETECT,
    input wire logic          O_FAST_ANALOG_SEQUENCE,
    input wire dtoc_shuffle_t O_ELEMENT_SHUFFLE,
    input wire logic          O_LEFT_SECONDARY_SCALE,
    input wire logic          O_RIGHT_SECONDARY_SCALE
);
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_NRST);
    // Writes land in the register first, the output flop one edge later
    wire logic wr_ok = I_CE && I_WR_EN;
    a_read_answer: assert property (I_CE && I_RD_EN |=> O_RVALID)
        else $error("read not answered");
    a_cfg_follow: assert property (wr_ok && I_ADDR == 8'h0b |-> ##2
        O_CAL_CFG == $past(I_WDATA[4:0], 2)) else $error("cal config wrong");
    a_speed_follow: assert property (wr_ok && I_ADDR == 8'h0e |-> ##2
        {O_FAST_CLOCK_LOSS_DETECT, O_FAST_ANALOG_SEQUENCE} == {$past(I_WDATA[4], 2),
        $past(I_WDATA[0], 2)}) else $error("speed-up flags wrong");
    a_short_follow: assert property (wr_ok && I_ADDR == 8'h0f |-> ##2
        O_SHORT_DETECT_EN == !$past(I_WDATA[4], 2)) else $error("short detect wrong");
    a_shuffle_map: assert property (wr_ok && I_ADDR == 8'h10 |-> ##2
        O_ELEMENT_SHUFFLE == ($past(I_WDATA[5:4], 2) == 2'h3 ? 2'h0 : $past(I_WDATA[5:4], 2)))
        else $error("shuffle code wrong");
    a_scale_follow: assert property (wr_ok && I_ADDR == 8'h11 |-> ##2
        {O_LEFT_SECONDARY_SCALE, O_RIGHT_SECONDARY_SCALE} == {$past(I_WDATA[7], 2),
        $past(I_WDATA[3], 2)}) else $error("scale bits wrong");
    a_phase_excl: assert property (!(O_CAL_COARSE && O_CAL_FINE))
        else $error("both phases high");
    a_done_single: assert property (O_CAL_DONE |=> !O_CAL_DONE && !O_CAL_FINE)
        else $error("done not a pulse");
    a_cancel_cause: assert property (O_OFS_CANCEL_GO |-> $past(I_OFS_CANCEL_REQ && I_CE))
        else $error("cancel without request");
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the tuning register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import dtoc_pkg::*;
;
    logic          I_MCLK = 1'b0, I_NRST = 1'b0, I_CE = 1'b1, I_WR_EN = 1'b0, I_RD_EN = 1'b0;
    logic          I_CAL_START = 1'b0, I_CAL_STEP = 1'b0, I_OFS_CANCEL_REQ = 1'b0;
    logic          I_CAL_SECOND_HALF = 1'b1;
    logic [7:0]    I_ADDR = 8'h00, I_WDATA = 8'h00, O_RDATA;
    logic [1:0]    I_BOND_OPT = 2'h0;
    logic [6:0]    O_CAL_STEP_IDX;
    logic          O_RVALID, O_CAL_FILTER_ACTIVE, O_CAL_COARSE, O_CAL_FINE, O_CAL_DONE;
    logic          O_OFS_CANCEL_GO, O_SHORT_DETECT_EN, O_FAST_CLOCK_LOSS_DETECT;
    logic          O_FAST_ANALOG_SEQUENCE, O_SEC_DITHER_NEGATIVE, O_DITHER_SETTING;
    logic          O_LEFT_SECONDARY_SCALE, O_RIGHT_SECONDARY_SCALE;
    dtoc_cal_cfg_t O_CAL_CFG;
    dtoc_shuffle_t O_ELEMENT_SHUFFLE;
    int            n_mismatch = 0, check_count = 0;
    dtoc_regs i_dtoc_regs (.*);
    always #25 I_MCLK = ~I_MCLK;
    // ----------------------------------------------------------------
    // Port tasks: inputs move at the falling edge only
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge I_MCLK);
        {I_WR_EN, I_ADDR, I_WDATA} = {1'b1, a, d};
        @(negedge I_MCLK);
        I_WR_EN = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge I_MCLK);
        {I_RD_EN, I_ADDR} = {1'b1, a};
        @(negedge I_MCLK);
        I_RD_EN = 1'b0;
        chk(8'(O_RVALID), 8'h01);
        chk(O_RDATA, e);
    endtask
    // Start, step and cancel request, one cycle each
    task automatic strobe(input logic [2:0] s);
        @(negedge I_MCLK);
        {I_CAL_START, I_CAL_STEP, I_OFS_CANCEL_REQ} = s;
        @(negedge I_MCLK);
        {I_CAL_START, I_CAL_STEP, I_OFS_CANCEL_REQ} = 3'h0;
    endtask
    task automatic do_reset;
        I_NRST = 1'b0;
        repeat (10) @(negedge I_MCLK);
        I_NRST = 1'b1;
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_regs;
        for (int a = 7; a <= 17; a++)
            rd(8'(a), a == 15 ? 8'h10 : (a == 16 ? 8'h20 : 8'h00));
        chk(8'(O_SHORT_DETECT_EN), 8'h00);
        chk(8'(O_ELEMENT_SHUFFLE), 8'h02);
        // Neighbours 0x06 and 0x12 must stay unmapped
        for (int a = 6; a <= 18; a++)
            wr(8'(a), 8'(a * 37));
        for (int a = 6; a <= 18; a++)
            rd(8'(a), (a < 7 || a > 17) ? 8'h00 : 8'(a * 37));
        I_CE = 1'b0;
        wr(8'h07, 8'h5a);
        I_CE = 1'b1;
        rd(8'h07, 8'h03);
        $display("t_regs end");
    endtask
    task automatic t_static;
        wr(8'h0e, 8'h11);
        wr(8'h0f, 8'hef);
        wr(8'h11, 8'h88);
        wr(8'h0b, 8'h15);
        @(negedge I_MCLK);
        chk({6'h00, O_FAST_CLOCK_LOSS_DETECT, O_FAST_ANALOG_SEQUENCE}, 8'h03);
        chk(8'(O_SHORT_DETECT_EN), 8'h01);
        chk({6'h00, O_LEFT_SECONDARY_SCALE, O_RIGHT_SECONDARY_SCALE}, 8'h03);
        chk(8'(O_CAL_CFG), 8'h15);
        for (int c = 0; c < 4; c++)
        begin
            wr(8'h10, 8'((c << 4) | (c & 1)));
            @(negedge I_MCLK);
            chk(8'(O_ELEMENT_SHUFFLE), c == 3 ? 8'h00 : 8'(c));
            chk(8'(O_SEC_DITHER_NEGATIVE), 8'(c & 1));
        end
        for (int b = 0; b < 4; b++)
        begin
            for (int k = 0; k < 4; k++)
                wr(8'(10 + k), k == b ? 8'h80 : 8'h00);
            for (int k = 0; k < 4; k++)
            begin
                I_BOND_OPT = 2'(k);
                repeat (4) @(negedge I_MCLK);
                chk(8'(O_DITHER_SETTING), 8'(k == b));
            end
        end
        $display("t_static end");
    endtask
    task automatic t_cal(input logic skip);
        I_CAL_SECOND_HALF = !skip;
        wr(8'h0b, {6'h00, skip, 1'b0});
        strobe(3'h4);
        chk({O_CAL_COARSE, O_CAL_STEP_IDX}, 8'h80);
        @(negedge I_MCLK);
        chk(8'(O_CAL_FILTER_ACTIVE), 8'(!skip));
        for (int i = 1; i < (skip ? 96 : 64); i++)
        begin
            strobe(3'h2);
            chk({O_CAL_COARSE, O_CAL_STEP_IDX}, 8'h80 | 8'(i));
        end
        strobe(3'h2);
        if (!skip)
        begin
            chk({O_CAL_FINE, O_CAL_STEP_IDX}, 8'h80);
            repeat (32) strobe(3'h2);
        end
        chk({5'h00, O_CAL_DONE, O_CAL_COARSE, O_CAL_FINE}, 8'h04);
        $display("t_cal end");
    endtask
    // First request after reset is granted even with later ones blocked
    task automatic t_cancel;
        do_reset();
        wr(8'h0f, 8'h11);
        strobe(3'h1);
        chk(8'(O_OFS_CANCEL_GO), 8'h01);
        strobe(3'h1);
        chk(8'(O_OFS_CANCEL_GO), 8'h00);
        wr(8'h0f, 8'h10);
        strobe(3'h1);
        chk(8'(O_OFS_CANCEL_GO), 8'h01);
        $display("t_cancel end");
    endtask
    initial
    begin
        do_reset();
        t_regs();
        t_static();
        t_cal(1'b0);
        t_cal(1'b1);
        t_cancel();
        wrap_up();
    end
    initial
    begin
        #1000000;
        n_mismatch++;
        wrap_up();
    end
endmodule
bind dtoc_regs dtoc_regs_asserts i_dtoc_regs_asserts (.I_MCLK, .I_NRST, .I_CE, .I_WR_EN,
    .I_RD_EN, .I_ADDR, .I_WDATA, .O_RVALID, .I_OFS_CANCEL_REQ, .O_OFS_CANCEL_GO, .O_CAL_CFG,
    .O_CAL_COARSE, .O_CAL_FINE, .O_CAL_DONE, .O_SHORT_DETECT_EN, .O_FAST_CLOCK_LOSS_DETECT,
    .O_FAST_ANALOG_SEQUENCE, .O_ELEMENT_SHUFFLE, .O_LEFT_SECONDARY_SCALE,
    .O_RIGHT_SECONDARY_SCALE);
`default_nettype wire
